/* File: design/bsx_exec.sv */
// Purpose: executes the bit-test-skip-if-set and subroutine jump
// Assumes: one instruction per cycle at clk_i; stack and memories outside
// Notes:   other opcodes simply advance the program counter by one
// Contract
// - subroutine jump decoded from upper nibble 1001
// - push program counter plus one on the jump's edge
// - immediate loads program counter bits 7..0
// - status page bits load counter bits 10..9
// - program counter bit 8 forced zero
`default_nettype none
module bsx_exec (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        instr_valid_i,
    input  wire logic [11:0] instr_i,
    input  wire logic [7:0]  reg_data_i,
    input  wire logic [7:0]  status_i,
    output logic [4:0]       reg_addr_o,
    output logic [10:0]      program_counter_o,
    output logic             stack_push_o,
    output logic [10:0]      stack_data_o,
    output logic             no_operation_cycle_o
);
    // one-hot sequencer codes; flush marks the slot whose word is dropped
    typedef enum logic [1:0] {
        BSX_RUN   = 2'h1,
        BSX_FLUSH = 2'h2
    } bsx_state_t;

    // sequencer group
    bsx_state_t  state;
    bsx_state_t  next_state;

    // program counter group
    logic [10:0] next_pc;

    // stack request group
    logic        next_push;
    logic [10:0] next_stack;

    // dropped-slot marker group
    logic        next_nop;

    // register address group
    logic [4:0]  next_addr;

    // decode of the word offered in this cycle
    logic [2:0]  bit_index;
    logic        tested_bit;
    logic        slot_dropped;
    logic        exec_slot;
    logic        call_now;
    logic        skip_now;
    logic        skip_taken;

    // counter step shared by ordinary, skipped and dropped slots
    function automatic logic [10:0] pc_step(
        input logic [10:0] pc
    );
        return pc + bsx_pkg::PC_STEP;
    endfunction

    // field extractors; positions come from the package only
    function automatic logic [3:0] opcode_of(
        input logic [11:0] word
    );
        return word[bsx_pkg::OPC_HI:bsx_pkg::OPC_LO];
    endfunction

    function automatic logic [2:0] bit_index_of(
        input logic [11:0] word
    );
        return word[bsx_pkg::BIDX_HI:bsx_pkg::BIDX_LO];
    endfunction

    function automatic logic [4:0] reg_addr_of(
        input logic [11:0] word
    );
        return word[bsx_pkg::FADDR_HI:bsx_pkg::FADDR_LO];
    endfunction

    // opcode tests used by the slot decode
    function automatic logic is_call(
        input logic [11:0] word
    );
        return opcode_of(word) == bsx_pkg::OPC_CALL;
    endfunction

    function automatic logic is_skip_set(
        input logic [11:0] word
    );
        return opcode_of(word) == bsx_pkg::OPC_SKIPSET;
    endfunction

    // bit 8 is forced low, so every entry sits in a lower half page
    function automatic logic [10:0] call_target(
        input logic [11:0] word,
        input logic [7:0]  status
    );
        return {
            status[bsx_pkg::PAGE_HI:bsx_pkg::PAGE_LO],
            bsx_pkg::PC8_CALL,
            word[bsx_pkg::IMM_HI:bsx_pkg::IMM_LO]
        };
    endfunction

    assign bit_index = bit_index_of(instr_i);

    // register data is expected back in the same cycle as the word
    bsx_bit_test u_bit (
        .data_i  (reg_data_i),
        .index_i (bit_index),
        .bit_o   (tested_bit)
    );

    // a word arriving in the dropped slot is never decoded
    assign slot_dropped = (state == BSX_FLUSH);
    assign exec_slot    = instr_valid_i && !slot_dropped;
    assign call_now     = exec_slot && is_call(instr_i);
    assign skip_now     = exec_slot && is_skip_set(instr_i);
    assign skip_taken   = skip_now && tested_bit;

    // sequencer: one dropped slot after a call or a taken skip
    always_comb begin
        next_state = BSX_RUN;
        case (state)
            BSX_RUN: begin
                // a clear bit or any other opcode keeps the one-cycle pace
                if (call_now || skip_taken) begin
                    next_state = BSX_FLUSH;
                end
            end
            BSX_FLUSH: begin
                // the flush lasts one cycle whatever arrives in it
                next_state = BSX_RUN;
            end
            default: begin
                // an illegal code falls back to normal execution
                next_state = BSX_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= BSX_RUN;
        end else begin
            state <= next_state;
        end
    end

    // program counter: the jump target, else one step per valid slot
    always_comb begin
        next_pc = program_counter_o;
        if (call_now) begin
            next_pc = call_target(instr_i, status_i);
        end else if (instr_valid_i) begin
            // skipped and dropped words still move the counter on, so it
            // always names the word after the one being offered
            next_pc = pc_step(program_counter_o);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            program_counter_o <= bsx_pkg::PC_RESET;
        end else begin
            program_counter_o <= next_pc;
        end
    end

    // stack request: return address leaves with the call, on the same edge as the jump
    always_comb begin
        next_push  = 1'b0;
        next_stack = stack_data_o;
        if (call_now) begin
            next_push  = 1'b1;
            next_stack = pc_step(program_counter_o);
        end
    end

    // the return address is held between pushes so the stack may latch late
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stack_push_o <= 1'b0;
            stack_data_o <= bsx_pkg::PC_RESET;
        end else begin
            stack_push_o <= next_push;
            stack_data_o <= next_stack;
        end
    end

    // dropped-slot marker: one pulse per flushed cycle
    // an idle bus during the flush still yields the pulse
    always_comb begin
        next_nop = slot_dropped;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            no_operation_cycle_o <= 1'b0;
        end else begin
            no_operation_cycle_o <= next_nop;
        end
    end

    // register address: informational copy, one cycle behind the word
    always_comb begin
        next_addr = reg_addr_of(instr_i);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_addr_o <= bsx_pkg::ADDR_RESET;
        end else begin
            reg_addr_o <= next_addr;
        end
    end

endmodule
`default_nettype wire

/* File: design/bsx_pkg.sv */
// Purpose: shared constants for the bit-skip and subroutine-jump executor
// Assumes: 12-bit instruction words, 11-bit program counter
// Notes:   field positions live here; port widths are written out in each module
`default_nettype none
package bsx_pkg;
    localparam int          INSTR_W     = 12;
    localparam int          PC_W        = 11;
    localparam int          DATA_W      = 8;
    localparam int          FADDR_W     = 5;
    localparam int          BIDX_W      = 3;
    localparam int          OPC_HI      = 11;
    localparam int          OPC_LO      = 8;
    localparam logic [3:0]  OPC_CALL    = 4'h9;
    localparam logic [3:0]  OPC_SKIPSET = 4'h7;
    localparam int          BIDX_HI     = 7;
    localparam int          BIDX_LO     = 5;
    localparam int          FADDR_HI    = 4;
    localparam int          FADDR_LO    = 0;
    localparam int          IMM_HI      = 7;
    localparam int          IMM_LO      = 0;
    localparam int          PAGE_HI     = 6;
    localparam int          PAGE_LO     = 5;
    localparam logic        PC8_CALL    = 1'h0;
    localparam logic [10:0] PC_RESET    = 11'h000;
    localparam logic [10:0] PC_STEP     = 11'h001;
    localparam logic [4:0]  ADDR_RESET  = 5'h00;
    localparam logic [11:0] INSTR_RESET = 12'h000;
endpackage
`default_nettype wire

/* File: design/bsx_bit_test.sv */
// Purpose: select one bit of an 8-bit data value
// Assumes: index within 0..7
// Notes:   purely combinational
`default_nettype none
module bsx_bit_test (
    input  wire logic [7:0] data_i,
    input  wire logic [2:0] index_i,
    output logic            bit_o
);
    assign bit_o = data_i[index_i];
endmodule
`default_nettype wire

/* File: sim/bsx_exec_monitor.sv */
// Purpose: checks the call and skip-if-set results at the executor ports
// Assumes: bound to the executor, sees its ports only
// Notes:   fl marks the slot dropped after a taken branch
`default_nettype none
module bsx_exec_monitor (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        instr_valid_i,
    input wire logic [11:0] instr_i,
    input wire logic [7:0]  reg_data_i,
    input wire logic [7:0]  status_i,
    input wire logic [10:0] program_counter_o,
    input wire logic        stack_push_o,
    input wire logic [10:0] stack_data_o,
    input wire logic        no_operation_cycle_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       fl;
    wire [10:0] pc  = program_counter_o;
    wire        no_operation_cycle = no_operation_cycle_o;
    wire        cl  = instr_valid_i && !fl && instr_i[11:8] == 4'h9;
    wire        sk  = instr_valid_i && !fl && instr_i[11:8] == 4'h7;
    wire        hit = reg_data_i[instr_i[7:5]];
    // a word in a dropped slot must not count as a new call or skip
    always_ff @(posedge clk_i) fl <= rst_n_i && (cl || sk && hit);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ret_push_a: assert property (cl |=> stack_push_o
        && stack_data_o == $past(pc) + 11'h1) else $error("bad push");
    pc_low_a: assert property (cl |=>
        pc[7:0] == $past(instr_i[7:0])) else $error("bad low bits");
    pc_page_a: assert property (cl |=>
        pc[10:9] == $past(status_i[6:5])) else $error("bad page bits");
    pc_bit8_a: assert property (cl |=> !pc[8] ##1 !stack_push_o)
        else $error("bad bit 8");
    skip_set_a: assert property (sk && hit |=> !no_operation_cycle ##1 no_operation_cycle)
        else $error("no skip slot");
    skip_clear_a: assert property (sk && !hit |=> !no_operation_cycle
        && pc == $past(pc) + 11'h1) else $error("bad step");
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: bench for the call and skip-if-set executor
// Assumes: inputs change at the falling edge of a 50 ns clock
// Notes:   step counts are left to the bound checker
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, rst_n_i = 0, instr_valid_i = 0;
    logic [11:0] instr_i = 12'h000;
    logic [7:0]  reg_data_i = 8'h00, status_i = 8'h00;
    logic [10:0] program_counter_o, stack_data_o, p;
    logic        stack_push_o, no_operation_cycle_o;
    logic [4:0]  reg_addr_o;
    int          err_count = 0, total_checks = 0, cyc = 0;
    bsx_exec uut (
        .clk_i                (clk_i),
        .rst_n_i              (rst_n_i),
        .instr_valid_i        (instr_valid_i),
        .instr_i              (instr_i),
        .reg_data_i           (reg_data_i),
        .status_i             (status_i),
        .reg_addr_o           (reg_addr_o),
        .program_counter_o    (program_counter_o),
        .stack_push_o         (stack_push_o),
        .stack_data_o         (stack_data_o),
        .no_operation_cycle_o (no_operation_cycle_o)
    );
    always #25 clk_i = ~clk_i;
    always @(negedge clk_i) if (++cyc > 400) close_out();
    task automatic chk(input string n, input logic [10:0] s, e);
        total_checks++;
        if (s !== e) err_count++;
        if (s !== e) $display("ERROR %s exp %h seen %h", n, e, s);
    endtask
    task automatic put(input logic [11:0] w, input logic [7:0] d);
        @(negedge clk_i);
        {instr_valid_i, instr_i, reg_data_i} = {1'b1, w, d};
    endtask
    // a call sits in the dropped slot to show it is ignored
    task automatic sc_call(input logic [7:0] k, input logic [1:0] g);
        status_i = {1'b0, g, 5'h1F};
        put({4'h9, k}, 8'h00);
        p = program_counter_o + 11'h1;
        put(12'h9FF, 8'h00);
        chk("ret", stack_data_o, p);
        chk("pc", program_counter_o, {g, 1'b0, k});
        put(12'h000, 8'h00);
        chk("nop", {10'h0, no_operation_cycle_o}, 11'h1);
    endtask
    task automatic sc_skip(input logic [2:0] b, input logic s);
        put({4'h7, b, 5'h03}, s ? 8'h01 << b : ~(8'h01 << b));
        put(12'h000, 8'hFF);
        chk("addr", {6'h0, reg_addr_o}, 11'h003);
        put(12'h000, 8'hFF);
        chk("skip", {10'h0, no_operation_cycle_o}, {10'h0, s});
    endtask
    // a taken skip followed by idle slots: the no-op still runs, pc waits
    task automatic sc_idle();
        put(12'h7E3, 8'h80);
        p = program_counter_o + 11'h1;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        @(negedge clk_i);
        chk("idle nop", {10'h0, no_operation_cycle_o}, 11'h1);
        chk("idle pc", program_counter_o, p);
        @(negedge clk_i);
        chk("held pc", program_counter_o, p);
    endtask
    // mid-run reset clears pc, return address, push and no-op outputs
    task automatic sc_reset();
        @(negedge clk_i);
        rst_n_i = 1'b0;
        @(negedge clk_i);
        chk("rst pc", program_counter_o, 11'h000);
        chk("rst ret", stack_data_o, 11'h000);
        chk("rst push", {10'h0, stack_push_o}, 11'h000);
        chk("rst nop", {10'h0, no_operation_cycle_o}, 11'h000);
        rst_n_i = 1'b1;
    endtask
    task automatic close_out();
        if (cyc > 400) err_count++;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_i);
        rst_n_i = 1;
        for (int i = 0; i < 16; i++) sc_skip(i[2:0], i[3]);
        sc_idle();
        // every call leaves pc bit 8 clear; the four calls walk page values 0 through 3
        for (int i = 0; i < 4; i++) sc_call(8'(255 - i * 85), i[1:0]);
        sc_reset();
        sc_call(8'h5A, 2'h1);
        close_out();
    end
endmodule
bind bsx_exec bsx_exec_monitor mon (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .instr_valid_i        (instr_valid_i),
    .instr_i              (instr_i),
    .reg_data_i           (reg_data_i),
    .status_i             (status_i),
    .program_counter_o    (program_counter_o),
    .stack_push_o         (stack_push_o),
    .stack_data_o         (stack_data_o),
    .no_operation_cycle_o (no_operation_cycle_o)
);
`default_nettype wire
